// [bench/fss_host_model.sv]
// Serial host model that frames register writes and reads.
// Assumes the bench resolves SDA as open drain with a pull-up.
`timescale 1ns/1ps
module fss_host_model (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // SCL stands high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // ==========================================================
  // Bit timing: a quarter of the 64 ns serial period
  task automatic q;
    repeat (2) @(negedge mclk);
  endtask

  // Data changes only while SCL is low
  task automatic bit_io(input logic b, output logic r);
    q;
    sda_low = !b;
    q;
    scl = 1'b1;
    q;
    q;
    r = sda;
    scl = 1'b0;
  endtask

  task automatic start;
    q;
    sda_low = 1'b0;
    q;
    scl = 1'b1;
    q;
    sda_low = 1'b1;
    q;
    scl = 1'b0;
  endtask

  task automatic stop;
    q;
    sda_low = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_low = 1'b0;
    q;
  endtask

  // Byte out MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] w, input logic ak,
                      output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], r[i]);
    end
    bit_io(ak, a);
  endtask

  // ==========================================================
  // Register access frames
  // host programs registers
  task automatic wr(input logic [6:0] ad, input logic [7:0] p,
                    input logic [7:0] d, output logic nk);
    logic [7:0] r;
    logic a0, a1, a2;
    start;
    xfer({ad, 1'b0}, 1'b1, r, a0);
    xfer(p, 1'b1, r, a1);
    xfer(d, 1'b1, r, a2);
    stop;
    nk = a0 | a1 | a2;
  endtask

  // Last read byte gets a NACK before the stop
  task automatic rd(input logic [6:0] ad, input logic [7:0] p,
                    output logic [7:0] d, output logic nk);
    logic [7:0] r;
    logic a0, a1, a2, a3;
    start;
    xfer({ad, 1'b0}, 1'b1, r, a0);
    xfer(p, 1'b1, r, a1);
    start;
    xfer({ad, 1'b1}, 1'b1, r, a2);
    xfer(8'hff, 1'b1, d, a3);
    stop;
    nk = a0 | a1 | a2;
  endtask
endmodule // fss_host_model

// [bench/tb_fanout_switch_select_control.sv]
// Self-checking bench of the fanout switch select control.
// Assumes the serial host model and a pull-down on the shared pins.
`timescale 1ns/1ps
`include "fss_consts.svh"
`define CHK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
  end \
end
module tb_fanout_switch_select_control;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic mode = 1'b0;
  logic [2:0] adr_lo = 3'h0;
  logic [5:0] pins = 6'h00;
  logic drv = 1'b1;
  logic sda_out, sda_oe, scl, host_low, nk;
  logic [3:0] pin_out, pin_oe, a_conn, b_conn;
  logic ce = 1'b1;
  logic [7:0] exp_sel = `FSS_SEL_EN_RST;
  logic [7:0] exp_comp = `FSS_COMP_RST;
  logic [7:0] rd_v;
  logic [6:0] dev;
  logic [31:0] rnd;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  wire sda = host_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);
  // Undriven shared pins fall to the pull-down
  wire [3:0] pin_lvl = (pin_oe & pin_out) | (~pin_oe & {4{drv}} & pins[3:0]);

  always #4 mclk = ~mclk;

  fss_switch_ctrl #(.NPORT(4)) dut (.mclk(mclk), .rstn(rstn), .ce(ce),
    .mode_strap(mode), .addr_strap(adr_lo), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .shared_ctrl_pin_in(pin_lvl),
    .shared_ctrl_pin_out(pin_out), .shared_ctrl_pin_oe(pin_oe),
    .b_select_in1(pins[4]), .b_enable_in(pins[5]), .a_conn(a_conn),
    .b_conn(b_conn));

  fss_host_model host (.mclk(mclk), .sda(sda), .scl(scl),
    .sda_low(host_low));

  // ==========================================================
  // Reference model
  function automatic logic [7:0] conn(input logic ae,
    input logic [1:0] as, input logic be, input logic [1:0] bs);
    logic [3:0] a, b;
    a = ae ? 4'h1 << as : 4'h0;
    b = (be && bs != as) ? 4'h1 << bs : 4'h0;
    return {b, a};
  endfunction

  task automatic chk_out;
    logic [7:0] e;
    logic [3:0] eo, ed;
    e = mode ? conn(exp_sel[4], exp_sel[3:2], exp_sel[7], exp_sel[6:5]) :
      conn(pins[2], pins[1:0], pins[5], pins[4:3]);
    eo = mode ? ~{exp_comp[7], exp_comp[5], exp_comp[3], exp_comp[1]} : 4'h0;
    ed = {exp_comp[6], exp_comp[4], exp_comp[2], exp_comp[0]} & eo;
    `CHK("a_conn", e[3:0], a_conn)
    `CHK("b_conn", e[7:4], b_conn)
    `CHK("conn", e, {b_conn, a_conn})
    `CHK("pin_oe", eo, pin_oe)
    `CHK("pin_out", ed, pin_out & pin_oe)
  endtask

  task automatic wr(input logic p, input logic [7:0] d);
    host.wr(dev, {7'h00, p}, d, nk);
    `CHK("wr_ack", 1'b0, nk)
    if (p) exp_comp = d;
    else exp_sel = d & `FSS_SEL_EN_WMASK;
  endtask

  task automatic rdchk(input logic p);
    host.rd(dev, {7'h00, p}, rd_v, nk);
    `CHK("rd_ack", 1'b0, nk)
    `CHK("reg", p ? exp_comp : exp_sel, rd_v)
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Whole run needs about 16000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      results;
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(20322));
    rnd = $urandom;
    @(negedge mclk);
    adr_lo = rnd[2:0];
    dev = {`FSS_ADDR_FIXED, rnd[2:0]};
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    repeat (4) @(negedge mclk);
    rdchk(1'b0);
    rdchk(1'b1);
    // Registers set but direct pins must steer
    wr(1'b0, 8'hff);
    rdchk(1'b0);
    for (int i = 0; i < 64; i++) begin
      pins = i[5:0];
      repeat (4) @(negedge mclk);
      chk_out;
    end
    // Clock enable low must freeze every flop: A stays on port 3
    ce = 1'b0;
    pins = 6'h25;
    repeat (4) @(negedge mclk);
    `CHK("ce_hold", 8'h08, {b_conn, a_conn})
    ce = 1'b1;
    repeat (4) @(negedge mclk);
    chk_out;
    host.wr(dev ^ 7'h01, 8'h00, 8'h00, nk);
    `CHK("bad_addr_nack", 1'b1, nk)
    rdchk(1'b0);
    drv = 1'b0;
    mode = 1'b1;
    repeat (4) @(negedge mclk);
    chk_out;
    for (int i = 0; i < 12; i++) begin
      rnd = $urandom;
      pins = rnd[21:16];
      wr(1'b0, rnd[7:0]);
      wr(1'b1, rnd[15:8]);
      repeat (4) @(negedge mclk);
      chk_out;
      rdchk(1'b0);
      rdchk(1'b1);
    end
    // Second reset in mid-run
    rstn = 1'b0;
    repeat (2) @(negedge mclk);
    `CHK("rst_conn", 8'h00, {b_conn, a_conn})
    rstn = 1'b1;
    exp_sel = `FSS_SEL_EN_RST;
    exp_comp = `FSS_COMP_RST;
    repeat (4) @(negedge mclk);
    chk_out;
    rdchk(1'b0);
    rdchk(1'b1);
    results;
  end
endmodule // tb_fanout_switch_select_control

// [core/fss_switch_ctrl.sv]
// Select and enable control of a 2:4 fanout switch with strap-chosen
// direct pins or a serial two-wire register interface.
// Assumes all pins are asynchronous to mclk; the serial clock is slow
// against mclk (bench: 64 ns period against 8 ns).
//
// Overview of operation
// - Strap low: direct pins steer the switches
// - Strap high: serial registers steer the switches
// - Shared pins: inputs in mode 0, outputs in mode 1 where the odd bit is zero
// - Dedicated B inputs float in mode 1
// - Mode 0: A enable pin gates switch A
// - Mode 0: B enable pin gates switch B
// - Mode 0: two A pins pick A target
// - Mode 0: two B pins pick B target
// - Mode 1: first register bits 7..2 steer
// - Mode 1: second register drives companion pins
// - Both registers writable and readable over serial
// - A enable field gates switch A
// - B enable field gates switch B
// - Two-bit select fields pick each target
// - First register low two bits read zero
// - Reset: first register zero, second 8'haa
// - Odd bit floats pin, even bit data
// - Same select code: B floats, even with A disabled
// - Select code is binary port index
`timescale 1ns/1ps
`include "fss_consts.svh"

module fss_switch_ctrl #(
  parameter int NPORT = 4
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic mode_strap,
  input wire logic [2:0] addr_strap,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [3:0] shared_ctrl_pin_in,
  output logic [3:0] shared_ctrl_pin_out,
  output logic [3:0] shared_ctrl_pin_oe,
  input wire logic b_select_in1,
  input wire logic b_enable_in,
  output logic [NPORT-1:0] a_conn,
  output logic [NPORT-1:0] b_conn
);

  // ==========================================================
  // Parameter check
  if (NPORT != 4) begin : g_nport_check
    $error("fss_switch_ctrl: NPORT must be 4");
  end

  // ==========================================================
  // Input synchronisers
  logic [11:0] sync1_ff;
  logic [11:0] sync2_ff;
  logic mode_q;
  logic [2:0] addr_q;
  logic ben_q;
  logic bsel1_q;
  logic [3:0] shared_q;
  logic scl_q;
  logic sda_q;
  logic scl_d_ff;
  logic sda_d_ff;
  assign {mode_q, addr_q, ben_q, bsel1_q, shared_q, scl_q, sda_q} = sync2_ff;

  // Serial lines reset high, so no false edge follows reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= `FSS_SYNC_RST;
      sync2_ff <= `FSS_SYNC_RST;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else if (ce) begin
      sync1_ff <= {mode_strap, addr_strap, b_enable_in, b_select_in1,
                   shared_ctrl_pin_in, scl_in, sda_in};
      sync2_ff <= sync1_ff;
      scl_d_ff <= scl_q;
      sda_d_ff <= sda_q;
    end
  end

  // ==========================================================
  // Serial line event detection

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl_q & ~scl_d_ff;
  assign scl_fall = ~scl_q & scl_d_ff;
  assign start_ev = scl_q & scl_d_ff & sda_d_ff & ~sda_q;
  assign stop_ev = scl_q & scl_d_ff & ~sda_d_ff & sda_q;

  // ==========================================================
  // Registers
  logic [7:0] sel_en_ff;
  logic [7:0] comp_ff;
  logic ptr_ff;
  logic [7:0] rd_byte;
  fss_pkg::fss_state_t st_ff;
  logic [7:0] sh_ff;
  logic [3:0] cnt_ff;
  logic rw_ff;
  logic wr_strobe;

  assign wr_strobe = ce & scl_fall & ~start_ev & ~stop_ev &
                     (st_ff == fss_pkg::FSS_WR) &
                     (cnt_ff == `FSS_BYTE_BITS);
  assign rd_byte = (ptr_ff == `FSS_IDX_COMP) ? comp_ff : sel_en_ff;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sel_en_ff <= `FSS_SEL_EN_RST;
      comp_ff <= `FSS_COMP_RST;
    end else if (wr_strobe) begin
      if (ptr_ff == `FSS_IDX_COMP) begin
        comp_ff <= sh_ff;
      end else begin
        sel_en_ff <= sh_ff & `FSS_SEL_EN_WMASK;
      end
    end
  end

  // ==========================================================
  // Serial slave
  logic sda_oe_ff;
  logic sda_out_ff;
  logic addr_hit;
  assign addr_hit = (sh_ff[7:1] == {`FSS_ADDR_FIXED, addr_q});

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sda_out_ff <= 1'b0;
      st_ff <= fss_pkg::FSS_IDLE;
      sh_ff <= 8'h00;
      cnt_ff <= `FSS_CNT_ZERO;
      rw_ff <= 1'b0;
      ptr_ff <= `FSS_IDX_SEL_EN;
      sda_oe_ff <= 1'b0;
    end else if (ce) begin
      if (start_ev) begin
        st_ff <= fss_pkg::FSS_ADDR;
        cnt_ff <= `FSS_CNT_ZERO;
        sda_oe_ff <= 1'b0;
      end else if (stop_ev) begin
        st_ff <= fss_pkg::FSS_IDLE;
        sda_oe_ff <= 1'b0;
      end else if (scl_rise) begin
        case (st_ff)
          fss_pkg::FSS_ADDR, fss_pkg::FSS_PTR, fss_pkg::FSS_WR: begin
            sh_ff <= {sh_ff[6:0], sda_q};
            cnt_ff <= cnt_ff + `FSS_CNT_ONE;
          end
          fss_pkg::FSS_RD: begin
            cnt_ff <= cnt_ff + `FSS_CNT_ONE;
          end
          fss_pkg::FSS_RD_ACK: begin
            // Host not acknowledging ends the read
            if (sda_q) begin
              st_ff <= fss_pkg::FSS_IDLE;
            end
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (st_ff)
          fss_pkg::FSS_ADDR: begin
            if (cnt_ff == `FSS_BYTE_BITS) begin
              if (addr_hit) begin
                st_ff <= fss_pkg::FSS_ADDR_ACK;
                rw_ff <= sh_ff[0];
                sda_oe_ff <= 1'b1;
              end else begin
                st_ff <= fss_pkg::FSS_IDLE;
              end
            end
          end
          fss_pkg::FSS_ADDR_ACK: begin
            cnt_ff <= `FSS_CNT_ZERO;
            if (rw_ff) begin
              st_ff <= fss_pkg::FSS_RD;
              sh_ff <= rd_byte;
              sda_oe_ff <= ~rd_byte[7];
            end else begin
              st_ff <= fss_pkg::FSS_PTR;
              sda_oe_ff <= 1'b0;
            end
          end
          fss_pkg::FSS_PTR: begin
            if (cnt_ff == `FSS_BYTE_BITS) begin
              // Only the low pointer bit decodes; two registers
              ptr_ff <= sh_ff[0];
              st_ff <= fss_pkg::FSS_PTR_ACK;
              sda_oe_ff <= 1'b1;
            end
          end
          fss_pkg::FSS_WR: begin
            if (cnt_ff == `FSS_BYTE_BITS) begin
              ptr_ff <= ~ptr_ff;
              st_ff <= fss_pkg::FSS_WR_ACK;
              sda_oe_ff <= 1'b1;
            end
          end
          fss_pkg::FSS_PTR_ACK, fss_pkg::FSS_WR_ACK: begin
            st_ff <= fss_pkg::FSS_WR;
            cnt_ff <= `FSS_CNT_ZERO;
            sda_oe_ff <= 1'b0;
          end
          fss_pkg::FSS_RD: begin
            if (cnt_ff == `FSS_BYTE_BITS) begin
              ptr_ff <= ~ptr_ff;
              st_ff <= fss_pkg::FSS_RD_ACK;
              sda_oe_ff <= 1'b0;
            end else begin
              sh_ff <= {sh_ff[6:0], 1'b0};
              sda_oe_ff <= ~sh_ff[6];
            end
          end
          fss_pkg::FSS_RD_ACK: begin
            st_ff <= fss_pkg::FSS_RD;
            cnt_ff <= `FSS_CNT_ZERO;
            sh_ff <= rd_byte;
            sda_oe_ff <= ~rd_byte[7];
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Source of enables and selects
  logic a_en;
  logic b_en;
  logic [1:0] a_sel;
  logic [1:0] b_sel;
  always_comb begin
    if (mode_q) begin
      a_en = sel_en_ff[`FSS_A_EN_BIT];
      b_en = sel_en_ff[`FSS_B_EN_BIT];
      a_sel = sel_en_ff[`FSS_A_SEL_HI:`FSS_A_SEL_LO];
      b_sel = sel_en_ff[`FSS_B_SEL_HI:`FSS_B_SEL_LO];
    end else begin
      a_en = shared_q[2];
      b_en = ben_q;
      a_sel = shared_q[1:0];
      b_sel = {bsel1_q, shared_q[3]};
    end
  end

  // ==========================================================
  // Per-port connection and companion pins
  logic [NPORT-1:0] a_conn_ff;
  logic [NPORT-1:0] b_conn_ff;
  logic [3:0] pin_out_ff;
  logic [3:0] pin_oe_ff;

  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          a_conn_ff[gi] <= 1'b0;
          b_conn_ff[gi] <= 1'b0;
        end else if (ce) begin
          a_conn_ff[gi] <= a_en & (a_sel == 2'(gi));
          b_conn_ff[gi] <= b_en & (b_sel == 2'(gi)) & (a_sel != b_sel);
        end
      end
    end
    for (gi = 0; gi < 4; gi++) begin : g_pin
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          pin_out_ff[gi] <= 1'b0;
          pin_oe_ff[gi] <= 1'b0;
        end else if (ce) begin
          pin_out_ff[gi] <= comp_ff[2*gi];
          pin_oe_ff[gi] <= mode_q & ~comp_ff[2*gi+1];
        end
      end
    end
  endgenerate

  // dedicated B inputs are never driven and go unread in mode 1
  assign sda_out = sda_out_ff;
  assign sda_oe = sda_oe_ff;
  assign shared_ctrl_pin_out = pin_out_ff;
  assign shared_ctrl_pin_oe = pin_oe_ff;
  assign a_conn = a_conn_ff;
  assign b_conn = b_conn_ff;

  // ==========================================================
  // Checks
  a_mode0_a_off: assert property (
    @(posedge mclk) disable iff (!rstn)
    ce && !mode_q && !shared_q[2] |=> a_conn_ff == 4'h0)
    else $error("switch A not opened by low enable pin");

  a_mode0_b_off: assert property (
    @(posedge mclk) disable iff (!rstn)
    ce && !mode_q && !ben_q |=> b_conn_ff == 4'h0)
    else $error("switch B not opened by low enable pin");

  a_mode0_a_sel: assert property (
    @(posedge mclk) disable iff (!rstn)
    ce && !mode_q && shared_q[2] && shared_q[1:0] == 2'h2
    |=> a_conn_ff == 4'h4)
    else $error("switch A pin code 2 not on port 2");

  a_mode0_b_sel: assert property (
    @(posedge mclk) disable iff (!rstn)
    ce && !mode_q && ben_q && !bsel1_q && shared_q[3] &&
    shared_q[1:0] == 2'h3 |=> b_conn_ff == 4'h2)
    else $error("switch B pin code 1 not on port 1");

  a_reg_a_en: assert property (
    @(posedge mclk) disable iff (!rstn)
    ce && mode_q && sel_en_ff[`FSS_A_EN_BIT] |=> $onehot(a_conn_ff))
    else $error("switch A not connected with enable field set");

  a_overlap_b_float: assert property (
    @(posedge mclk) disable iff (!rstn)
    (a_conn_ff & b_conn_ff) == 4'h0)
    else $error("A and B on the same port");

  a_low_bits_zero: assert property (
    @(posedge mclk) disable iff (!rstn)
    sel_en_ff[1:0] == 2'h0)
    else $error("first register low bits not zero");

  a_pins_drive: assert property (
    @(posedge mclk) disable iff (!rstn)
    ce && mode_q && !comp_ff[1]
    |=> pin_oe_ff[0] && pin_out_ff[0] == $past(comp_ff[0]))
    else $error("companion pin 0 not driven from register");

  a_pins_float: assert property (
    @(posedge mclk) disable iff (!rstn)
    ce && !mode_q |=> pin_oe_ff == 4'h0)
    else $error("shared pins driven in mode 0");

  a_write_lands: assert property (
    @(posedge mclk) disable iff (!rstn)
    wr_strobe && ptr_ff == `FSS_IDX_COMP |=> comp_ff == $past(sh_ff))
    else $error("serial write did not land");

endmodule // fss_switch_ctrl

// [include/fss_consts.svh]
// Constants of the fanout switch select control: register fields,
// reset values, serial address and bit counts.
// Assumes inclusion by the design file and the bench of this block.
`ifndef FSS_CONSTS_SVH
`define FSS_CONSTS_SVH

// ==========================================================
// Register map
`define FSS_IDX_SEL_EN 1'h0
`define FSS_IDX_COMP 1'h1
`define FSS_SEL_EN_RST 8'h00
`define FSS_COMP_RST 8'haa
`define FSS_SEL_EN_WMASK 8'hfc

// ==========================================================
// Fields of switch_select_enable
`define FSS_B_EN_BIT 7
`define FSS_B_SEL_HI 6
`define FSS_B_SEL_LO 5
`define FSS_A_EN_BIT 4
`define FSS_A_SEL_HI 3
`define FSS_A_SEL_LO 2

// ==========================================================
// Serial interface
`define FSS_ADDR_FIXED 4'h7
`define FSS_BYTE_BITS 4'h8
`define FSS_CNT_ZERO 4'h0
`define FSS_CNT_ONE 4'h1
// Synchroniser reset: serial lines at their idle high level
`define FSS_SYNC_RST 12'h003

`endif

// [include/fss_pkg.sv]
// Types of the fanout switch select control.
// Assumes nothing of its surroundings.
package fss_pkg;

  // ==========================================================
  // Serial slave states, one-hot
  typedef enum logic [8:0] {
    FSS_IDLE     = 9'h001,
    FSS_ADDR     = 9'h002,
    FSS_ADDR_ACK = 9'h004,
    FSS_PTR      = 9'h008,
    FSS_PTR_ACK  = 9'h010,
    FSS_WR       = 9'h020,
    FSS_WR_ACK   = 9'h040,
    FSS_RD       = 9'h080,
    FSS_RD_ACK   = 9'h100
  } fss_state_t;

endpackage
